// [core/owp_timer.sv]
// module: one-shot and wait-then-pulse timer with an axi4-lite register slave
//
// The AXI4-Lite register port was left to the implementer.
module owp_timer (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // axi4-lite write address
   input wire logic [11:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   // axi4-lite write data
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   // axi4-lite write response
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // axi4-lite read address
   input wire logic [11:0] araddr,
   input wire logic arvalid,
   output logic arready,
   // axi4-lite read data
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // pins and companion timer
   input wire logic extTriggerPin,
   input wire logic companionUnderflow,
   output logic pulseOutputPin,
   output logic timerIrq,
   output logic pinIrq
);
   typedef struct packed {
      logic awready;
      logic wready;
      logic awHeld;
      logic [11:0] awAddr;
      logic wHeld;
      logic [31:0] wData;
      logic [3:0] wStrb;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [7:0] ioCtrl;
      logic countStart;
      logic countStatus;
      logic forceStop;
      logic waitMode;
      logic [1:0] srcSel;
      logic bothEdge;
      logic intPol;
      logic intReq;
      logic [7:0] preReload;
      logic [7:0] secReload;
      logic [7:0] priReload;
      logic [7:0] preCnt;
      logic [7:0] mainCnt;
      owp_pkg::owp_phase_t phase;
      logic activeFlag;
      logic trigPend;
      logic [1:0] trigAge;
      logic stopPend;
      logic [2:0] div;
      logic [2:0] pinSync;
      logic pinLevel;
      logic companionPrev;
      logic pulseOut;
      logic timerIrq;
      logic pinIrq;
   } owp_state_t;

   owp_state_t s_q;
   owp_state_t s_d;

   always_comb begin
      logic tick;
      logic doWrite;
      logic pinRise;
      logic pinFall;
      logic pinEdgeTrig;
      logic pinEdgeInt;
      logic swStart;
      logic swStop;
      logic running;
      logic [31:0] rd;
      s_d = s_q;
      tick = 1'b0;
      doWrite = 1'b0;
      swStart = 1'b0;
      swStop = 1'b0;
      rd = 32'h0;
      pinRise = 1'b0;
      pinFall = 1'b0;
      pinEdgeTrig = 1'b0;
      pinEdgeInt = 1'b0;
      running = s_q.phase != owp_pkg::PH_IDLE;

      // synchronise the trigger pin, edge from the agreeing stages
      s_d.pinSync = {s_q.pinSync[1:0], extTriggerPin};
      if (s_q.pinSync[2] == s_q.pinSync[1]) begin
         s_d.pinLevel = s_q.pinSync[2];
      end
      pinRise = s_d.pinLevel & ~s_q.pinLevel;
      pinFall = ~s_d.pinLevel & s_q.pinLevel;
      // timer trigger edge selection
      pinEdgeTrig = s_q.bothEdge ? (pinRise | pinFall) : (s_q.ioCtrl[owp_pkg::IOC_TRIG_POL] ? pinRise : pinFall);
      // interrupt edge ignores the trigger polarity bit
      pinEdgeInt = s_q.bothEdge ? (pinRise | pinFall) : (s_q.intPol ? pinRise : pinFall);

      // count source selection
      s_d.div = s_q.div + 3'h1;
      s_d.companionPrev = companionUnderflow;
      case (s_q.srcSel)
         owp_pkg::SRC_F1: tick = 1'b1;
         owp_pkg::SRC_F2: tick = s_q.div[0];
         owp_pkg::SRC_F8: tick = s_q.div == 3'h7;
         owp_pkg::SRC_EXT: tick = companionUnderflow & ~s_q.companionPrev;
         default: tick = 1'b0;
      endcase

      // axi4-lite write path
      s_d.timerIrq = 1'b0;
      s_d.pinIrq = 1'b0;
      if (awvalid && s_q.awready) begin
         s_d.awHeld = 1'b1;
         s_d.awAddr = awaddr;
         s_d.awready = 1'b0;
      end
      if (wvalid && s_q.wready) begin
         s_d.wHeld = 1'b1;
         s_d.wData = wdata;
         s_d.wStrb = wstrb;
         s_d.wready = 1'b0;
      end
      if (s_q.awHeld && s_q.wHeld && !s_q.bvalid) begin
         doWrite = 1'b1;
         s_d.awHeld = 1'b0;
         s_d.wHeld = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp = owp_pkg::RESP_OKAY;
      end
      if (s_q.bvalid && bready) begin
         s_d.bvalid = 1'b0;
         s_d.awready = 1'b1;
         s_d.wready = 1'b1;
      end
      if (doWrite && s_q.wStrb[0]) begin
         case ({s_q.awAddr[11:2], 2'b00})
            owp_pkg::ADDR_IO_CTRL_WORD: s_d.ioCtrl = s_q.wData[7:0] & owp_pkg::IOC_WRITE_MASK;
            owp_pkg::ADDR_TIMER_CTRL: begin
               s_d.countStart = s_q.wData[owp_pkg::TCR_START];
               s_d.forceStop = s_q.wData[owp_pkg::TCR_FORCE_STOP];
            end
            owp_pkg::ADDR_ONESHOT_CTRL: begin
               // commands act once and are not stored
               swStart = s_q.wData[owp_pkg::OCR_START];
               swStop = s_q.wData[owp_pkg::OCR_STOP];
            end
            owp_pkg::ADDR_MODE: begin
               s_d.waitMode = s_q.wData[owp_pkg::MODE_WAIT];
               s_d.srcSel = s_q.wData[owp_pkg::MODE_SRC_HI:owp_pkg::MODE_SRC_LO];
            end
            owp_pkg::ADDR_PRESCALER: begin
               s_d.preReload = s_q.wData[7:0];
               if (!running) s_d.preCnt = s_q.wData[7:0];
            end
            owp_pkg::ADDR_SECONDARY: s_d.secReload = s_q.wData[7:0];
            owp_pkg::ADDR_PRIMARY: begin
               s_d.priReload = s_q.wData[7:0];
               if (!running) s_d.mainCnt = s_q.wData[7:0];
            end
            owp_pkg::ADDR_PIN_INT: begin
               s_d.bothEdge = s_q.wData[owp_pkg::PIN_BOTH_EDGE];
               s_d.intPol = s_q.wData[owp_pkg::PIN_INT_POL];
               if (s_q.wData[owp_pkg::PIN_REQ]) s_d.intReq = 1'b0;
            end
            default: s_d.bresp = owp_pkg::RESP_SLVERR;
         endcase
      end else if (doWrite) begin
         case ({s_q.awAddr[11:2], 2'b00})
            owp_pkg::ADDR_IO_CTRL_WORD, owp_pkg::ADDR_TIMER_CTRL, owp_pkg::ADDR_ONESHOT_CTRL, owp_pkg::ADDR_MODE,
            owp_pkg::ADDR_PRESCALER, owp_pkg::ADDR_SECONDARY, owp_pkg::ADDR_PRIMARY, owp_pkg::ADDR_PIN_INT: ;
            default: s_d.bresp = owp_pkg::RESP_SLVERR;
         endcase
      end

      // pin interrupt request updates regardless of timer state
      if (pinEdgeInt) begin
         s_d.intReq = 1'b1;
         s_d.pinIrq = 1'b1;
      end

      // count status follows the start bit on a source tick
      if (tick) s_d.countStatus = s_q.countStart;

      // trigger capture: only while counting enabled and not active
      if (s_q.countStatus && !s_q.activeFlag && !s_q.trigPend &&
          (swStart || (pinEdgeTrig && s_q.ioCtrl[owp_pkg::IOC_TRIG_EN]))) begin
         s_d.trigPend = 1'b1;
         s_d.trigAge = 2'h0;
      end
      if (swStop) s_d.stopPend = 1'b1;

      // sequence engine, advanced on count source ticks
      if (s_q.forceStop || !s_q.countStart || s_q.stopPend) begin
         // any stop reloads the counters first
         s_d.phase = owp_pkg::PH_IDLE;
         s_d.activeFlag = 1'b0;
         s_d.trigPend = 1'b0;
         s_d.stopPend = 1'b0;
         s_d.preCnt = s_q.preReload;
         s_d.mainCnt = s_q.priReload;
         if (s_q.forceStop) s_d.countStatus = 1'b0;
      end else if (tick) begin
         if (s_q.trigPend) begin
            // active flag raised on the second tick after capture
            if (s_q.trigAge == 2'h1) begin
               s_d.trigPend = 1'b0;
               s_d.activeFlag = 1'b1;
               s_d.preCnt = s_q.preReload;
               s_d.mainCnt = s_q.priReload;
               s_d.phase = s_q.waitMode ? owp_pkg::PH_WAIT : owp_pkg::PH_PULSE;
            end else begin
               s_d.trigAge = s_q.trigAge + 2'h1;
            end
         end else if (running) begin
            // (n+1)(m+1) and (n+1)(p+1) periods
            if (s_q.preCnt != 8'h00) begin
               s_d.preCnt = s_q.preCnt - 8'h01;
            end else begin
               s_d.preCnt = s_q.preReload;
               if (s_q.mainCnt != 8'h00) begin
                  s_d.mainCnt = s_q.mainCnt - 8'h01;
               end else if (s_q.phase == owp_pkg::PH_WAIT) begin
                  s_d.mainCnt = s_q.secReload;
                  s_d.phase = owp_pkg::PH_PULSE;
               end else begin
                  s_d.mainCnt = s_q.priReload;
                  s_d.phase = owp_pkg::PH_IDLE;
                  s_d.activeFlag = 1'b0;
                  s_d.timerIrq = 1'b1;
               end
            end
         end
      end

      // output level: active during pulse, idle otherwise and during wait
      s_d.pulseOut = (s_d.phase == owp_pkg::PH_PULSE) ^ s_q.ioCtrl[owp_pkg::IOC_OUT_LEVEL];

      // axi4-lite read path
      case ({araddr[11:2], 2'b00})
         owp_pkg::ADDR_IO_CTRL_WORD: rd = {24'h0, 4'h0, s_q.ioCtrl[3:0]};
         owp_pkg::ADDR_TIMER_CTRL: rd = {29'h0, s_q.forceStop, s_q.countStatus, s_q.countStart};
         owp_pkg::ADDR_ONESHOT_CTRL: rd = {29'h0, s_q.activeFlag, 2'b00};
         owp_pkg::ADDR_MODE: rd = {29'h0, s_q.srcSel, s_q.waitMode};
         owp_pkg::ADDR_PRESCALER: rd = {24'h0, s_q.preCnt};
         owp_pkg::ADDR_SECONDARY: rd = {24'h0, s_q.secReload};
         owp_pkg::ADDR_PRIMARY: rd = {24'h0, s_q.mainCnt};
         owp_pkg::ADDR_PIN_INT: rd = {29'h0, s_q.intReq, s_q.intPol, s_q.bothEdge};
         default: rd = 32'h0;
      endcase
      if (arvalid && s_q.arready) begin
         s_d.arready = 1'b0;
         s_d.rvalid = 1'b1;
         s_d.rdata = rd;
         case ({araddr[11:2], 2'b00})
            owp_pkg::ADDR_IO_CTRL_WORD, owp_pkg::ADDR_TIMER_CTRL, owp_pkg::ADDR_ONESHOT_CTRL, owp_pkg::ADDR_MODE,
            owp_pkg::ADDR_PRESCALER, owp_pkg::ADDR_SECONDARY, owp_pkg::ADDR_PRIMARY, owp_pkg::ADDR_PIN_INT:
               s_d.rresp = owp_pkg::RESP_OKAY;
            default: s_d.rresp = owp_pkg::RESP_SLVERR;
         endcase
      end
      if (s_q.rvalid && rready) begin
         s_d.rvalid = 1'b0;
         s_d.arready = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s_q <= '0;
         s_q.awready <= 1'b1;
         s_q.wready <= 1'b1;
         s_q.arready <= 1'b1;
         s_q.ioCtrl <= owp_pkg::IOC_RESET;
         s_q.phase <= owp_pkg::PH_IDLE;
         s_q.preReload <= owp_pkg::VALUE_RESET;
         s_q.secReload <= owp_pkg::VALUE_RESET;
         s_q.priReload <= owp_pkg::VALUE_RESET;
         s_q.preCnt <= owp_pkg::VALUE_RESET;
         s_q.mainCnt <= owp_pkg::VALUE_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   assign awready = s_q.awready;
   assign wready = s_q.wready;
   assign bvalid = s_q.bvalid;
   assign bresp = s_q.bresp;
   assign arready = s_q.arready;
   assign rvalid = s_q.rvalid;
   assign rdata = s_q.rdata;
   assign rresp = s_q.rresp;
   assign pulseOutputPin = s_q.pulseOut;
   assign timerIrq = s_q.timerIrq;
   assign pinIrq = s_q.pinIrq;
endmodule

// [core/owp_pkg.sv]
// package: register map, field positions and reset values of the one-shot pulse timer
package owp_pkg;
   // io control: register index, and its byte address at four times the index
   localparam logic [11:0] ADDR_IO_CTRL = 12'h10a;
   localparam logic [11:0] ADDR_IO_CTRL_WORD = 12'h428;
   // remaining register byte addresses (word aligned)
   localparam logic [11:0] ADDR_TIMER_CTRL = 12'h200;
   localparam logic [11:0] ADDR_ONESHOT_CTRL = 12'h204;
   localparam logic [11:0] ADDR_MODE = 12'h208;
   localparam logic [11:0] ADDR_PRESCALER = 12'h20c;
   localparam logic [11:0] ADDR_SECONDARY = 12'h210;
   localparam logic [11:0] ADDR_PRIMARY = 12'h214;
   localparam logic [11:0] ADDR_PIN_INT = 12'h218;
   // pulse_io_control fields
   localparam int IOC_OUT_LEVEL = 0;
   localparam int IOC_OUT_SWITCH = 1;
   localparam int IOC_TRIG_EN = 2;
   localparam int IOC_TRIG_POL = 3;
   localparam logic [7:0] IOC_WRITE_MASK = 8'h0f;
   localparam logic [7:0] IOC_RESET = 8'h00;
   // timer_control_reg fields
   localparam int TCR_START = 0;
   localparam int TCR_STATUS = 1;
   localparam int TCR_FORCE_STOP = 2;
   // oneshot_control_reg fields
   localparam int OCR_START = 0;
   localparam int OCR_STOP = 1;
   localparam int OCR_ACTIVE = 2;
   // mode register fields
   localparam int MODE_WAIT = 0;
   localparam int MODE_SRC_LO = 1;
   localparam int MODE_SRC_HI = 2;
   // pin interrupt register fields
   localparam int PIN_BOTH_EDGE = 0;
   localparam int PIN_INT_POL = 1;
   localparam int PIN_REQ = 2;
   // count source selections
   localparam logic [1:0] SRC_F1 = 2'h0;
   localparam logic [1:0] SRC_F2 = 2'h1;
   localparam logic [1:0] SRC_F8 = 2'h2;
   localparam logic [1:0] SRC_EXT = 2'h3;
   localparam logic [7:0] VALUE_RESET = 8'hff;
   // axi responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {PH_IDLE, PH_WAIT, PH_PULSE} owp_phase_t;
endpackage

// [verification/owp_far_end.sv]
// far-side model: external trigger source and pulse-width measuring load
module owp_far_end (
   // clock
   input wire logic clk,
   // trigger source
   input wire logic trigLevel,
   output logic extTriggerPin,
   // load on the pulse pin
   input wire logic pulseOutputPin,
   input wire logic activeLow,
   output int pulseCount,
   output int pulseWidth
);
   timeunit 1ns;
   timeprecision 1ns;
   int run = 0;
   initial begin
      extTriggerPin = 1'b0;
      pulseCount = 0;
      pulseWidth = 0;
   end
   // pin moves just after the edge; width counts clocks at active level
   always @(posedge clk) begin
      extTriggerPin <= trigLevel;
      if (pulseOutputPin ^ activeLow) run++;
      else if (run != 0) begin
         pulseWidth <= run;
         pulseCount <= pulseCount + 1;
         run = 0;
      end
   end
endmodule

// [verification/owp_timer_checker.sv]
// checker: bus handshake and pulse timing properties of the timer
module owp_timer_checker (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // register bus
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic [11:0] araddr,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   input wire logic rvalid,
   input wire logic rready,
   // pins
   input wire logic pulseOutputPin,
   input wire logic timerIrq,
   input wire logic pinIrq
);
   logic [11:0] rdAddr_q;
   logic [2:0] chgAge_q;
   logic outPrev_q;
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   // read address of the pending answer and age of the last pin change
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rdAddr_q <= 12'h000;
         chgAge_q <= 3'h7;
         outPrev_q <= 1'b0;
      end else begin
         if (arvalid && arready) rdAddr_q <= araddr;
         outPrev_q <= pulseOutputPin;
         if (pulseOutputPin != outPrev_q) chgAge_q <= 3'h0;
         else if (chgAge_q != 3'h7) chgAge_q <= chgAge_q + 3'h1;
      end
   end
   a_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
      else $error("write response late");
   a_read_answer: assert property (arvalid && arready |=> rvalid && !arready)
      else $error("read response late");
   a_read_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read data dropped");
   a_write_hold: assert property (bvalid && !bready |=> bvalid)
      else $error("write response dropped");
   a_err_zero: assert property (rvalid && rresp == owp_pkg::RESP_SLVERR |-> rdata == 32'h0)
      else $error("error read not zero");
   a_upper_zero: assert property (rvalid && rdAddr_q == owp_pkg::ADDR_IO_CTRL_WORD |-> rdata[7:4] == 4'h0)
      else $error("unassigned bits set");
   a_irq_single: assert property (timerIrq |=> !timerIrq)
      else $error("timer request too long");
   a_irq_at_end: assert property (timerIrq |-> ##[0:3] (chgAge_q < 3'h4))
      else $error("timer request away from pulse end");
   a_pin_single: assert property (pinIrq |=> !pinIrq)
      else $error("pin request too long");
   cover property (timerIrq);
   cover property (pinIrq);
   cover property (rvalid && rresp == owp_pkg::RESP_SLVERR);
endmodule

// [verification/owp_timer_tb.sv]
// testbench: register bus driver, shot table and trigger cases
module owp_timer_tb;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {logic mode; logic [1:0] src; logic lvl; int width;} owp_row_t;
   logic clk, resetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rdVal;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, rdResp, wrResp;
   logic trigLevel, compSrc, pulseOutputPin, timerIrq, pinIrq, extTriggerPin, activeLow;
   int miscompares = 0, comparisons = 0, pulseCount, pulseWidth, irqCount = 0, pinCount = 0, base, i0;
   owp_row_t rows[6] = '{'{0, owp_pkg::SRC_F1, 0, 8}, '{0, owp_pkg::SRC_F2, 1, 16}, '{0, owp_pkg::SRC_F8, 0, 64},
      '{0, owp_pkg::SRC_EXT, 1, 16}, '{1, owp_pkg::SRC_F1, 0, 6}, '{1, owp_pkg::SRC_F2, 1, 12}};
   owp_timer dut (.clk(clk), .resetn(resetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready), .extTriggerPin(extTriggerPin), .companionUnderflow(compSrc),
      .pulseOutputPin(pulseOutputPin), .timerIrq(timerIrq), .pinIrq(pinIrq));
   owp_far_end far (.clk(clk), .trigLevel(trigLevel), .extTriggerPin(extTriggerPin),
      .pulseOutputPin(pulseOutputPin), .activeLow(activeLow), .pulseCount(pulseCount), .pulseWidth(pulseWidth));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      compSrc <= !compSrc;
      if (timerIrq === 1'b1) irqCount++;
      if (pinIrq === 1'b1) pinCount++;
   end
   task automatic end_sim;
      if (miscompares == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tmo;
      miscompares++;
      $display("mismatch %0t wait ran out", $time);
      end_sim;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         n++;
      end while (!bvalid && n < 50);
      wrResp = bresp;
      bready <= 1'b0;
      if (n >= 50) tmo;
   endtask
   task automatic rd(input logic [11:0] a);
      int n;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
         n++;
      end while (!rvalid && n < 50);
      rdVal = rdata;
      rdResp = rresp;
      rready <= 1'b0;
      if (n >= 50) tmo;
   endtask
   task automatic idle(input int k);
      repeat (k) @(posedge clk);
   endtask
   task automatic shot_wait(input int inc);
      int n;
      for (n = 0; n < 300 && (inc == 0 || pulseCount - base < inc); n++) @(posedge clk);
      chk(pulseCount - base, inc);
      if (inc != 0 && n == 300) tmo;
   endtask
   task automatic pin(input logic l, input int inc);
      base = pulseCount;
      i0 = pinCount;
      trigLevel <= l;
      shot_wait(inc);
   endtask
   initial begin
      {resetn, awvalid, wvalid, bready, arvalid, rready, trigLevel, compSrc, activeLow} = '0;
      {awaddr, araddr, wdata} = '0;
      wstrb = 4'hf;
      repeat (20) @(posedge clk);
      resetn <= 1'b1;
      rd(owp_pkg::ADDR_IO_CTRL_WORD);
      chk(rdVal, 32'h0);
      rd(owp_pkg::ADDR_PRESCALER);
      chk(rdVal, 32'hff);
      wr(owp_pkg::ADDR_IO_CTRL_WORD, 32'h000000ff);
      rd(owp_pkg::ADDR_IO_CTRL_WORD);
      chk(rdVal, 32'h0000000f);
      rd(12'h300);
      chk(rdResp, owp_pkg::RESP_SLVERR);
      chk(rdVal, 32'h0);
      wr(12'h300, 32'h0);
      chk(wrResp, owp_pkg::RESP_SLVERR);
      wr(owp_pkg::ADDR_PRESCALER, 32'h1);
      chk(wrResp, owp_pkg::RESP_OKAY);
      wr(owp_pkg::ADDR_PRIMARY, 32'h3);
      wr(owp_pkg::ADDR_SECONDARY, 32'h2);
      wstrb <= 4'h0;
      wr(owp_pkg::ADDR_PRIMARY, 32'h7);
      wstrb <= 4'hf;
      rd(owp_pkg::ADDR_PRIMARY);
      chk(rdVal, 32'h3);
      foreach (rows[i]) begin
         wr(owp_pkg::ADDR_MODE, {29'h0, rows[i].src, rows[i].mode});
         wr(owp_pkg::ADDR_IO_CTRL_WORD, {31'h0, rows[i].lvl});
         activeLow <= rows[i].lvl;
         wr(owp_pkg::ADDR_TIMER_CTRL, 32'h1);
         idle(40);
         chk(pulseOutputPin, rows[i].lvl);
         base = pulseCount;
         i0 = irqCount;
         wr(owp_pkg::ADDR_ONESHOT_CTRL, 32'h1);
         idle(3);
         if (rows[i].mode) chk(pulseOutputPin, rows[i].lvl);
         shot_wait(1);
         chk(pulseWidth, rows[i].width);
         idle(4);
         chk(irqCount - i0, 1);
         wr(owp_pkg::ADDR_TIMER_CTRL, 32'h0);
      end
      wr(owp_pkg::ADDR_MODE, 32'h0);
      wr(owp_pkg::ADDR_IO_CTRL_WORD, 32'h0);
      activeLow <= 1'b0;
      idle(20);
      base = pulseCount;
      wr(owp_pkg::ADDR_ONESHOT_CTRL, 32'h1);
      shot_wait(0);
      wr(owp_pkg::ADDR_TIMER_CTRL, 32'h1);
      idle(10);
      base = pulseCount;
      wr(owp_pkg::ADDR_ONESHOT_CTRL, 32'h1);
      rd(owp_pkg::ADDR_ONESHOT_CTRL);
      chk(rdVal, 32'h4);
      wr(owp_pkg::ADDR_ONESHOT_CTRL, 32'h1);
      shot_wait(1);
      chk(pulseWidth, 8);
      rd(owp_pkg::ADDR_ONESHOT_CTRL);
      chk(rdVal, 32'h0);
      base = pulseCount;
      shot_wait(0);
      wr(owp_pkg::ADDR_PIN_INT, 32'h2);
      wr(owp_pkg::ADDR_IO_CTRL_WORD, 32'h0000000c);
      pin(1, 1);
      pin(0, 0);
      wr(owp_pkg::ADDR_IO_CTRL_WORD, 32'h00000004);
      pin(1, 0);
      chk(pinCount - i0, 1);
      pin(0, 1);
      wr(owp_pkg::ADDR_PIN_INT, 32'h1);
      pin(1, 1);
      pin(0, 1);
      wr(owp_pkg::ADDR_IO_CTRL_WORD, 32'h0);
      pin(1, 0);
      pin(0, 0);
      wr(owp_pkg::ADDR_IO_CTRL_WORD, 32'h0000000c);
      wr(owp_pkg::ADDR_PIN_INT, 32'h6);
      base = pulseCount;
      wr(owp_pkg::ADDR_ONESHOT_CTRL, 32'h1);
      trigLevel <= 1'b1;
      shot_wait(1);
      chk(pulseWidth, 8);
      rd(owp_pkg::ADDR_PIN_INT);
      chk(rdVal[2], 1'b1);
      base = pulseCount;
      wr(owp_pkg::ADDR_ONESHOT_CTRL, 32'h1);
      wr(owp_pkg::ADDR_ONESHOT_CTRL, 32'h2);
      shot_wait(1);
      chk(pulseWidth < 8, 1'b1);
      rd(owp_pkg::ADDR_PRIMARY);
      chk(rdVal, 32'h3);
      base = pulseCount;
      wr(owp_pkg::ADDR_ONESHOT_CTRL, 32'h1);
      wr(owp_pkg::ADDR_TIMER_CTRL, 32'h5);
      shot_wait(1);
      chk(pulseWidth < 8, 1'b1);
      rd(owp_pkg::ADDR_TIMER_CTRL);
      chk(rdVal, 32'h5);
      end_sim;
   end
endmodule
bind owp_timer owp_timer_checker chk_i (.clk(clk), .resetn(resetn), .awvalid(awvalid), .awready(awready),
   .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
   .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
   .pulseOutputPin(pulseOutputPin), .timerIrq(timerIrq), .pinIrq(pinIrq));
